// >>> logic/level_quant.v
// Maps an ADC reading of the level divider to a clamped level code.
// Assumes the reading is already in the sys_clk domain.
`timescale 1ns/10ps
`include "out_latch_regs.vh"
module level_quant (
    // Measurement
    input  wire [`ADC_W-1:0]   adc_code,
    // Level code
    output wire [`LEVEL_W-1:0] level_code
);
    // Scale full range onto 0..57: code = adc*58/256
    wire [15:0] prod;
    wire [7:0]  scaled;

    assign prod       = adc_code * 8'd58;
    assign scaled     = prod[15:8];
    // Clamp keeps the code inside 0..57 even for an out-of-range scale
    assign level_code = (scaled > {2'b00, `LEVEL_MAX}) ? `LEVEL_MAX
                                                       : scaled[`LEVEL_W-1:0];
endmodule // level_quant

// >>> logic/out_latch_ctrl.v
// Status output latch/momentary control, power-down gating and level hold.
// Assumes validated control messages arrive as a strobe with a line mask,
// and the level divider is digitised by an external converter.
`timescale 1ns/10ps
`include "out_latch_regs.vh"
module out_latch_ctrl (
    // Clock and reset
    input  wire                   sys_clk,
    input  wire                   nrst,
    // Pins
    input  wire                   latch_all_pin,
    input  wire                   power_down_n_pin,
    input  wire [`ADC_W-1:0]      tx_level_setting_input,
    // Received control message from the initiating_unit
    input  wire                   msg_valid,
    input  wire [`NUM_LINES-1:0]  msg_lines,
    input  wire [`NUM_LINES-1:0]  msg_perm,
    // Outputs
    output reg  [`NUM_LINES-1:0]  status_out,
    output reg  [`LEVEL_W-1:0]    tx_level,
    output reg                    powered_down,
    // AXI4-Lite slave
    input  wire [3:0]             s_axi_awaddr,
    input  wire                   s_axi_awvalid,
    output reg                    s_axi_awready,
    input  wire [31:0]            s_axi_wdata,
    input  wire [3:0]             s_axi_wstrb,
    input  wire                   s_axi_wvalid,
    output reg                    s_axi_wready,
    output reg  [1:0]             s_axi_bresp,
    output reg                    s_axi_bvalid,
    input  wire                   s_axi_bready,
    input  wire [3:0]             s_axi_araddr,
    input  wire                   s_axi_arvalid,
    output reg                    s_axi_arready,
    output reg  [31:0]            s_axi_rdata,
    output reg  [1:0]             s_axi_rresp,
    output reg                    s_axi_rvalid,
    input  wire                   s_axi_rready
);
    localparam N = `NUM_LINES;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    wire              latch_all_s;
    wire              pwr_n_s;
    wire [`ADC_W-1:0] adc_s;
    wire [`LEVEL_W-1:0] level_q;

    sync2 #(.W(2)) u_sync_ctl (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .d       ({latch_all_pin, power_down_n_pin}),
        .q       ({latch_all_s, pwr_n_s})
    );

    sync2 #(.W(`ADC_W)) u_sync_adc (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .d       (tx_level_setting_input),
        .q       (adc_s)
    );

    level_quant u_quant (
        .adc_code   (adc_s),
        .level_code (level_q)
    );

    // ****************************************
    // Configuration registers
    // ****************************************
    reg [N-1:0] latch_cfg_r;
    reg [N-1:0] perm_mask_r;
    reg         level_taken_r;
    reg [1:0]   settle_r;
    reg         pwr_prev_r;

    // Latched line set: per-line choice, overridden by latch-all pin
    wire [N-1:0] latched_mode = latch_all_s ? {N{1'b1}} : latch_cfg_r;
    // Lines this sender may control: message mask and local mask
    wire [N-1:0] allowed = msg_perm & perm_mask_r;
    wire [N-1:0] cmd     = msg_lines & allowed;
    wire         run     = pwr_n_s;
    wire         wake    = pwr_n_s & ~pwr_prev_r;

    // ****************************************
    // Stream tracking and timeout
    // ****************************************
    reg [14:0] gap_cnt_r;
    reg        stream_r;
    reg [N-1:0] armed_r;
    // Any valid message while powered up restarts the gap; the stream ends one timeout later
    wire        gap_done = ({17'h0, gap_cnt_r} == (`RX_TIMEOUT_CYC - 1));

    always @(posedge sys_clk) begin
        if (!nrst) begin
            gap_cnt_r <= 15'h0000;
            stream_r  <= 1'b0;
        end else if (!run) begin
            gap_cnt_r <= 15'h0000;
            stream_r  <= 1'b0;
        end else if (msg_valid) begin
            gap_cnt_r <= 15'h0000;
            stream_r  <= 1'b1;
        end else if (stream_r) begin
            if (gap_done) begin
                stream_r <= 1'b0;
            end else begin
                gap_cnt_r <= gap_cnt_r + 15'h0001;
            end
        end
    end

    // ****************************************
    // Status outputs
    // ****************************************
    reg [N-1:0] mom_r;
    reg [N-1:0] lat_r;
    reg [N-1:0] mom_nxt;
    reg [N-1:0] lat_nxt;
    reg [N-1:0] armed_nxt;
    integer i;

    always @* begin
        mom_nxt   = mom_r;
        lat_nxt   = lat_r;
        armed_nxt = armed_r;
        for (i = 0; i < N; i = i + 1) begin
            if (msg_valid) begin
                mom_nxt[i] = cmd[i];
                if (cmd[i] && armed_r[i]) begin
                    lat_nxt[i]   = ~lat_r[i];
                    armed_nxt[i] = 1'b0;
                end
            end else if (!stream_r) begin
                mom_nxt[i]   = 1'b0;
                armed_nxt[i] = 1'b1;
            end
            // A line enters latched mode low, never from a stale toggle
            if (!latched_mode[i]) begin
                lat_nxt[i] = 1'b0;
            end
        end
    end

    // Each line shows its latched or its momentary state
    wire [N-1:0] status_nxt = (latched_mode & lat_nxt) | (~latched_mode & mom_nxt);

    always @(posedge sys_clk) begin
        if (!nrst) begin
            mom_r      <= {N{1'b0}};
            lat_r      <= {N{1'b0}};
            armed_r    <= {N{1'b1}};
            status_out <= {N{1'b0}};
        end else begin
            if (!run || wake) begin
                mom_r      <= {N{1'b0}};
                lat_r      <= {N{1'b0}};
                armed_r    <= {N{1'b1}};
                status_out <= {N{1'b0}};
            end else begin
                mom_r      <= mom_nxt;
                lat_r      <= lat_nxt;
                armed_r    <= armed_nxt;
                status_out <= status_nxt;
            end
        end
    end

    // ****************************************
    // Power state
    // ****************************************
    // Bus stays alive while down; status_out, the line state and the stream tracking return to their reset values
    always @(posedge sys_clk) begin
        if (!nrst) begin
            pwr_prev_r   <= 1'b0;
            powered_down <= 1'b1;
        end else begin
            pwr_prev_r   <= pwr_n_s;
            powered_down <= ~run;
        end
    end

    // ****************************************
    // Power-up level capture
    // ****************************************
    // Waits three cycles after release so the synchronised reading is fresh
    // Read once only: a new divider setting needs another reset
    always @(posedge sys_clk) begin
        if (!nrst) begin
            level_taken_r <= 1'b0;
            settle_r      <= 2'b00;
            tx_level      <= `LEVEL_MAX;
        end else if (!level_taken_r) begin
            if (settle_r == `LEVEL_SETTLE) begin
                tx_level      <= level_q;
                level_taken_r <= 1'b1;
            end else begin
                settle_r <= settle_r + 2'b01;
            end
        end
    end

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    reg [3:0]  aw_r;
    reg        aw_have_r;
    reg [31:0] w_r;
    reg [3:0]  ws_r;
    reg        w_have_r;
    wire       do_wr = aw_have_r && w_have_r && !s_axi_bvalid;
    wire [7:0] wbyte = ws_r[0] ? w_r[7:0] : 8'h00;

    always @(posedge sys_clk) begin
        if (!nrst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            aw_have_r     <= 1'b0;
            w_have_r      <= 1'b0;
            aw_r          <= 4'h0;
            w_r           <= 32'h00000000;
            ws_r          <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_r          <= s_axi_awaddr;
                aw_have_r     <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_r          <= s_axi_wdata;
                ws_r         <= s_axi_wstrb;
                w_have_r     <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_wr) begin
                aw_have_r    <= 1'b0;
                w_have_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `RESP_OKAY;
                case (aw_r)
                    `REG_LATCH_CFG,
                    `REG_PERM_MASK,
                    `REG_STATUS,
                    `REG_LEVEL: ;
                    default: s_axi_bresp <= `RESP_SLVERR;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Config registers hold the low byte lane only
    wire       wr_cfg  = do_wr && (aw_r == `REG_LATCH_CFG) && ws_r[0];
    wire       wr_mask = do_wr && (aw_r == `REG_PERM_MASK) && ws_r[0];

    always @(posedge sys_clk) begin
        if (!nrst) begin
            latch_cfg_r <= `LATCH_CFG_RST;
            perm_mask_r <= `PERM_MASK_RST;
        end else begin
            if (wr_cfg) begin
                latch_cfg_r <= wbyte;
            end
            if (wr_mask) begin
                perm_mask_r <= wbyte;
            end
        end
    end

    // Read word decoded ahead of the flop so the bus outputs stay registered
    reg [31:0] rdata_nxt;
    reg [1:0]  rresp_nxt;

    always @* begin
        rdata_nxt = 32'h00000000;
        rresp_nxt = `RESP_OKAY;
        case (s_axi_araddr)
            `REG_LATCH_CFG: rdata_nxt = {24'h000000, latch_cfg_r};
            `REG_PERM_MASK: rdata_nxt = {24'h000000, perm_mask_r};
            `REG_STATUS:    rdata_nxt = {21'h0, powered_down, latch_all_s,
                                         stream_r, status_out};
            `REG_LEVEL:     rdata_nxt = {25'h0, level_taken_r, tx_level};
            default:        rresp_nxt = `RESP_SLVERR;
        endcase
    end

    always @(posedge sys_clk) begin
        if (!nrst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rdata_nxt;
            s_axi_rresp   <= rresp_nxt;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule // out_latch_ctrl

// >>> logic/sync2.v
// Two-flop synchroniser for pin inputs.
// Assumes asynchronous inputs into the sys_clk domain.
`timescale 1ns/10ps
module sync2 #(
    parameter W = 1
) (
    // Clock and reset
    input  wire         sys_clk,
    input  wire         nrst,
    // Data
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);
    reg [W-1:0] meta_r;

    always @(posedge sys_clk) begin
        if (!nrst) begin
            meta_r <= {W{1'b0}};
            q      <= {W{1'b0}};
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule // sync2

// >>> shared/out_latch_regs.vh
// Constants, register map and timing counts for the output latch and power level block.
// Assumes a 250 MHz sys_clk and a 32-bit AXI4-Lite register port.
`ifndef OUT_LATCH_REGS_VH
`define OUT_LATCH_REGS_VH

`define NUM_LINES        8
`define LEVEL_W          6
`define LEVEL_MAX        6'h39
`define LEVEL_STEPS      58
`define ADC_W            8

// Register byte offsets
`define REG_LATCH_CFG    4'h0
`define REG_PERM_MASK    4'h4
`define REG_STATUS       4'h8
`define REG_LEVEL        4'hc

`define LATCH_CFG_RST    8'h00
`define PERM_MASK_RST    8'hff

// Message gap that ends a stream, in microseconds, and derived cycles
`define RX_TIMEOUT_US    100
`define CLK_MHZ          250
`define RX_TIMEOUT_CYC   (`RX_TIMEOUT_US * `CLK_MHZ)
// Clocks waited after reset release before level capture, past the synchroniser
`define LEVEL_SETTLE     2'b11

`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`endif

// >>> tb/out_latch_props.sv
// Checker on the output latch block ports.
// Assumes one sys_clk domain and a synchronous active-low nrst.
`timescale 1ns/10ps
`include "out_latch_regs.vh"
module out_latch_props (
    // Clock and reset
    input wire                  sys_clk,
    input wire                  nrst,
    // Pin and messages
    input wire                  power_down_n_pin,
    input wire                  msg_valid,
    input wire [`NUM_LINES-1:0] msg_perm,
    // Outputs
    input wire [`NUM_LINES-1:0] status_out,
    input wire [`LEVEL_W-1:0]   tx_level,
    input wire                  powered_down,
    // Bus handshakes
    input wire                  s_axi_awvalid,
    input wire                  s_axi_awready,
    input wire                  s_axi_wvalid,
    input wire                  s_axi_wready,
    input wire                  s_axi_bvalid,
    input wire                  s_axi_arvalid,
    input wire                  s_axi_arready,
    input wire                  s_axi_rvalid
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // Saturating age since reset; level capture is long done at 15
    reg [3:0] age_r;
    always @(posedge sys_clk) begin
        if (!nrst) begin
            age_r <= 4'h0;
        end else if (age_r != 4'hf) begin
            age_r <= age_r + 4'h1;
        end
    end
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_pd_low;
        !power_down_n_pin [*4];
    endsequence
    property p_wr_resp; s_wr_taken |-> ##2 s_axi_bvalid; endproperty
    property p_wr_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    property p_rd_resp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    property p_pd_enter; s_pd_low |=> powered_down; endproperty
    property p_pd_quiet; powered_down [*3] |-> status_out == 8'h00; endproperty
    property p_lvl_max; tx_level <= `LEVEL_MAX; endproperty
    property p_lvl_hold; age_r == 4'hf |-> $stable(tx_level); endproperty
    property p_perm;
        msg_valid |=> (status_out & ~$past(status_out) & ~$past(msg_perm)) == 8'h00;
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write response late");
    a_wr_busy: assert property (p_wr_busy) else $error("write taken while busy");
    a_rd_resp: assert property (p_rd_resp) else $error("read data late");
    a_pd_enter: assert property (p_pd_enter) else $error("power down missed");
    a_pd_quiet: assert property (p_pd_quiet) else $error("output while down");
    a_lvl_max: assert property (p_lvl_max) else $error("level above top");
    a_lvl_hold: assert property (p_lvl_hold) else $error("level changed");
    a_perm: assert property (p_perm) else $error("unauthorised line set");
endmodule // out_latch_props

// >>> tb/ru_msg_source.sv
// Model of the initiating_unit message stream seen by the block.
// Assumes the caller waits whole clocks between streams.
`timescale 1ns/10ps
`include "out_latch_regs.vh"
module msg_source (
    // Clock
    input wire                  sys_clk,
    // Message strobe
    output reg                  msg_valid,
    output reg [`NUM_LINES-1:0] msg_lines,
    output reg [`NUM_LINES-1:0] msg_perm
);
    initial begin
        msg_valid = 1'b0;
        msg_lines = 8'h00;
        msg_perm = 8'h00;
    end
    // Idle payload is inverted so stale values never look valid
    task send(input [7:0] l, input [7:0] p, input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            msg_valid <= 1'b1;
            msg_lines <= l;
            msg_perm <= p;
            @(posedge sys_clk);
            msg_valid <= 1'b0;
            msg_lines <= ~l;
            msg_perm <= ~p;
            repeat (gap) @(posedge sys_clk);
        end
    endtask
    // Drops the payload lines ahead of a power-down
    task quiet;
        @(posedge sys_clk);
        msg_lines <= 8'h00;
        msg_perm <= 8'h00;
    endtask
endmodule // msg_source

// >>> tb/testbench.sv
// Self-checking bench for the output latch and level block.
// Assumes the message model and checker are compiled first.
`timescale 1ns/10ps
`include "out_latch_regs.vh"
module testbench;
    reg         sys_clk = 1'b0;
    reg         nrst = 1'b0;
    reg         latch_all_pin = 1'b0;
    reg         power_down_n_pin = 1'b1;
    reg  [7:0]  tx_level_setting_input = 8'hff;
    wire        msg_valid, powered_down;
    wire [7:0]  msg_lines, msg_perm, status_out;
    wire [5:0]  tx_level;
    reg  [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    reg  [31:0] s_axi_wdata = 32'h0;
    reg         s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    reg         s_axi_arvalid = 0, s_axi_rready = 0;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    integer     n_errors = 0;
    integer     checks_done = 0;
    reg  [31:0] rd;
    reg  [1:0]  resp;
    reg  [7:0]  lv_in [0:2] = '{8'hff, 8'h00, 8'h80};
    reg  [5:0]  lv_exp [0:2] = '{6'h39, 6'h00, 6'h1d};
    always #2 sys_clk = ~sys_clk;
    out_latch_ctrl dut (.sys_clk, .nrst, .latch_all_pin, .power_down_n_pin,
        .tx_level_setting_input, .msg_valid, .msg_lines, .msg_perm, .status_out, .tx_level,
        .powered_down, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    msg_source src (.sys_clk, .msg_valid, .msg_lines, .msg_perm);
    // ****************************************
    // Tasks
    // ****************************************
    task cyc(input integer n);
        repeat (n) @(posedge sys_clk);
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        checks_done = checks_done + 1;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            n_errors = n_errors + 1;
        end
    endtask
    task do_reset;
        nrst <= 1'b0;
        cyc(2);
        nrst <= 1'b1;
        cyc(12);
    endtask
    task axi_wr(input [3:0] a, input [31:0] d);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task axi_rd(input [3:0] a);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task complete_run;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        cyc(90000);
        n_errors = n_errors + 1;
        complete_run;
    end
    initial begin
        for (int i = 0; i < 3; i++) begin
            tx_level_setting_input <= lv_in[i];
            do_reset;
            chk("tx_level", lv_exp[i], tx_level);
            chk("status_out", 0, status_out);
            tx_level_setting_input <= ~lv_in[i];
            cyc(20);
            chk("tx_level held", lv_exp[i], tx_level);
        end
        chk("powered_down", 0, powered_down);
        axi_rd(`REG_LATCH_CFG);
        chk("latch_cfg", 0, rd);
        axi_rd(`REG_PERM_MASK);
        chk("perm_mask", 32'hff, rd);
        axi_wr(`REG_LEVEL, 32'h0);
        chk("bresp", `RESP_OKAY, resp);
        axi_rd(`REG_LEVEL);
        chk("level reg", 32'h5d, rd);
        chk("rresp", `RESP_OKAY, resp);
        // Momentary with both masks trimming lines
        axi_wr(`REG_PERM_MASK, 32'h7f);
        src.send(8'hff, 8'hf7, 3, 50);
        chk("status", 8'h77, status_out);
        cyc(23900);
        chk("status", 8'h77, status_out);
        cyc(1200);
        chk("status", 0, status_out);
        // Latched by pin, then line 1 alone by config
        axi_wr(`REG_LATCH_CFG, 32'h02);
        latch_all_pin <= 1'b1;
        cyc(5);
        src.send(8'h03, 8'hff, 3, 50);
        chk("status", 8'h03, status_out);
        cyc(25100);
        chk("status", 8'h03, status_out);
        axi_rd(`REG_STATUS);
        chk("status reg", 32'h203, rd);
        latch_all_pin <= 1'b0;
        cyc(5);
        src.send(8'h03, 8'hff, 2, 50);
        chk("status", 8'h01, status_out);
        cyc(25100);
        chk("status", 0, status_out);
        src.send(8'h02, 8'hff, 1, 5);
        chk("status", 8'h02, status_out);
        // Inputs low before powering down
        tx_level_setting_input <= 8'h00;
        s_axi_wdata <= 32'h0;
        s_axi_wstrb <= 4'h0;
        s_axi_araddr <= 4'h0;
        src.quiet;
        power_down_n_pin <= 1'b0;
        cyc(8);
        chk("powered_down", 1, powered_down);
        src.send(8'h01, 8'hff, 1, 5);
        chk("status", 0, status_out);
        power_down_n_pin <= 1'b1;
        cyc(8);
        chk("powered_down", 0, powered_down);
        chk("status", 0, status_out);
        complete_run;
    end
endmodule // testbench
bind out_latch_ctrl out_latch_props u_props (.sys_clk, .nrst, .power_down_n_pin, .msg_valid,
    .msg_perm, .status_out, .tx_level, .powered_down, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
